// ==== wdt_pkg.sv ====
// Purpose: Shared constants for the postscaled watchdog
// Assumes: 100 MHz reference clock, 8-bit register port
// Notes:   Offsets index an 8-bit register file
package wdt_pkg;
    // Clock and base period
    localparam int CLK_PERIOD_PS   = 10000;
    localparam int BASE_PERIOD_MS  = 4;
    // Divide first: 4 ms in picoseconds does not fit a 32-bit int
    localparam int BASE_TICK_CYCLES =
        BASE_PERIOD_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int PS_WIDTH        = 16;
    localparam int ADDR_WIDTH      = 4;
    localparam int DATA_WIDTH      = 8;

    // Register offsets
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] CFG_OFS  = 4'h1;
    localparam logic [3:0] RSTC_OFS = 4'h2;
    localparam logic [3:0] STAT_OFS = 4'h3;
    localparam logic [3:0] MASK_OFS = 4'h4;
    localparam logic [3:0] OSCF_OFS = 4'h5;

    // Field positions
    localparam int SWEN_BIT   = 0;
    localparam int CFG_EN_LSB = 0;
    localparam int CFG_PS_LSB = 2;
    localparam int TO_BIT     = 3;
    localparam int EV_TIMEOUT = 0;
    localparam int EV_CLEARED = 1;
    localparam int EV_WIDTH   = 2;
    localparam int OSCF_WIDTH = 3;

    // Enable field codes
    localparam logic [1:0] EN_ALWAYS = 2'h3;
    localparam logic [1:0] EN_SOFT   = 2'h2;
    localparam logic [1:0] EN_AWAKE  = 2'h1;
    localparam logic [1:0] EN_OFF    = 2'h0;

    // Reset values and masks
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] CFG_MASK  = 8'h3F;
    localparam logic [7:0] DATA_ZERO = 8'h00;
endpackage

// ==== postscale_if.sv ====
// Purpose: Carrier between watchdog control and its postscaler
// Assumes: One clock domain
// Notes:   tick is a one-cycle pulse, clr is held high while disabled, sel is a level
`timescale 1ns/1ps
interface postscale_if;
    logic       tick;   // Base period elapsed
    logic       clr;    // Clear postscaler count
    logic [3:0] sel;    // Postscale select
    logic       expire; // Selected output reached
    modport ctl (output tick, output clr, output sel, input expire);
    modport ps  (input tick, input clr, input sel, output expire);
endinterface

// ==== wdt_postscaler.sv ====
// Purpose: 16-bit postscaler with power-of-two output select
// Assumes: Ticks and clears arrive from the same clock domain
// Notes:   expire is a one-cycle registered pulse
`timescale 1ns/1ps
module wdt_postscaler (
    input  wire logic ref_clk_i, // 100 MHz clock
    input  wire logic rst_i,     // Synchronous reset, high
    postscale_if.ps   ps_bus     // Tick, clear and select
);
    logic [wdt_pkg::PS_WIDTH-1:0] count_ff;
    logic                         expire_ff;
    logic [wdt_pkg::PS_WIDTH-1:0] last_val;

    // Terminal count of ratio 2**sel, 1:1 up to 1:32768
    assign last_val = (wdt_pkg::PS_WIDTH)'((17'h1 << ps_bus.sel) - 17'h1);

    // Count ticks; clear beats a tick in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || ps_bus.clr) begin
            count_ff <= '0;
        end else if (ps_bus.tick) begin
            if (count_ff == last_val) begin
                count_ff <= '0;
            end else begin
                count_ff <= count_ff + 16'h0001;
            end
        end
    end

    // Registered expiry pulse
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            expire_ff <= 1'b0;
        end else begin
            expire_ff <= ps_bus.tick && !ps_bus.clr &&
                         (count_ff == last_val);
        end
    end

    assign ps_bus.expire = expire_ff;

    chk_unity_ratio: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (ps_bus.tick && !ps_bus.clr && ps_bus.sel == 4'h0)
            |=> ps_bus.expire)
        else $error("Ratio 1:1 did not expire on tick");

    chk_clear_count: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        ps_bus.clr |=> (count_ff == 16'h0000) && !ps_bus.expire)
        else $error("Postscaler not cleared");
endmodule

// ==== watchdog_timer_postscaled.sv ====
// Purpose: Watchdog with base tick, postscaler and register port
// Assumes: CPU strobes and config word are on ref_clk_i
// Notes:   clk_fail_i is asynchronous and is synchronised here
`timescale 1ns/1ps
module watchdog_timer_postscaled #(
    parameter int TICK_CYCLES = wdt_pkg::BASE_TICK_CYCLES
) (
    input  wire logic       ref_clk_i,     // 100 MHz clock
    input  wire logic       rst_i,         // Synchronous reset, high
    input  wire logic [3:0] addr_i,        // Register offset
    input  wire logic [7:0] wdata_i,       // Write data
    input  wire logic       we_i,          // Write strobe
    input  wire logic       re_i,          // Read strobe
    output logic      [7:0] rdata_o,       // Read data, next cycle
    input  wire logic [7:0] config_word_i, // Configuration word
    input  wire logic       clear_instr_i, // Clear instruction pulse
    input  wire logic       sleep_instr_i, // Sleep instruction pulse
    input  wire logic       sleeping_i,    // Device asleep level
    input  wire logic       clk_fail_i,    // Clock failure, async
    output logic            osc_enable_o,  // Oscillator request
    output logic            dev_reset_o,   // Device reset pulse
    output logic            wake_o,        // Wake-up pulse
    output logic            irq_o          // Interrupt level
);
    postscale_if ps_bus ();

    logic [7:0]                    ctrl_ff;
    logic [7:0]                    rdata_ff;
    logic [wdt_pkg::OSCF_WIDTH-1:0] oscf_ff;
    logic                          to_ff;
    logic [wdt_pkg::EV_WIDTH-1:0]  stat_ff;
    logic [wdt_pkg::EV_WIDTH-1:0]  mask_ff;
    logic                          en_ff;
    logic [31:0]                   div_ff;
    logic                          tick_ff;
    logic                          fail_s1_ff;
    logic                          fail_s2_ff;
    logic                          fail_s3_ff;
    logic                          reset_ff;
    logic                          wake_ff;
    logic                          irq_ff;
    logic                          fail_edge;
    logic                          freq_chg;
    logic                          clear_any;
    logic                          nxt_en;
    logic [7:0]                    nxt_rdata;
    logic [wdt_pkg::EV_WIDTH-1:0]  ev_set;
    logic [wdt_pkg::EV_WIDTH-1:0]  w1c;
    logic [1:0]                    cfg_en;
    logic [3:0]                    cfg_ps;

    // Decode of the enable field against sleep and software bit
    function automatic logic en_decode(input logic [1:0] code,
                                       input logic       swen,
                                       input logic       asleep);
        logic res;
        res = 1'b0;
        unique case (code)
            wdt_pkg::EN_ALWAYS: res = 1'b1;
            wdt_pkg::EN_SOFT:   res = swen;
            wdt_pkg::EN_AWAKE:  res = !asleep;
            wdt_pkg::EN_OFF:    res = 1'b0;
        endcase
        return res;
    endfunction

    // Address match for a strobe
    function automatic logic hit(input logic       strobe,
                                 input logic [3:0] a,
                                 input logic [3:0] ofs);
        return strobe && (a == ofs);
    endfunction

    // Configuration fields, fuse-like and static
    assign cfg_en = config_word_i[wdt_pkg::CFG_EN_LSB +: 2];
    assign cfg_ps = config_word_i[wdt_pkg::CFG_PS_LSB +: 4];

    // Clock failure pin: two flops, then an edge stage
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fail_s1_ff <= 1'b0;
            fail_s2_ff <= 1'b0;
            fail_s3_ff <= 1'b0;
        end else begin
            fail_s1_ff <= clk_fail_i;
            fail_s2_ff <= fail_s1_ff;
            fail_s3_ff <= fail_s2_ff;
        end
    end

    assign fail_edge = fail_s2_ff && !fail_s3_ff;

    // Frequency select change, only a different value counts
    assign freq_chg = hit(we_i, addr_i, wdt_pkg::OSCF_OFS) &&
                      (wdata_i[wdt_pkg::OSCF_WIDTH-1:0] != oscf_ff);

    // All counter clear sources; a disabled watchdog also rests at zero
    assign clear_any = clear_instr_i || sleep_instr_i
                     || freq_chg
                     || fail_edge
                     || !en_ff;

    assign nxt_en = en_decode(cfg_en, ctrl_ff[wdt_pkg::SWEN_BIT],
                              sleeping_i);

    // Enable state, which also requests the oscillator
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            en_ff <= 1'b0;
        end else begin
            en_ff <= nxt_en;
        end
    end

    // Control register, only the software enable bit is stored
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_ff <= wdt_pkg::CTRL_RST;
        end else if (hit(we_i, addr_i, wdt_pkg::CTRL_OFS)) begin
            ctrl_ff <= {7'h00, wdata_i[wdt_pkg::SWEN_BIT]};
        end
    end

    // Oscillator frequency select register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            oscf_ff <= '0;
        end else if (hit(we_i, addr_i, wdt_pkg::OSCF_OFS)) begin
            oscf_ff <= wdata_i[wdt_pkg::OSCF_WIDTH-1:0];
        end
    end

    // Base period divider standing in for the slow oscillator;
    // it only runs while the oscillator is requested
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || clear_any) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == 32'(TICK_CYCLES - 1)) begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 32'h00000001;
            tick_ff <= 1'b0;
        end
    end

    // Postscaler connection; 15 doublings of 4 ms reach 131.072 s
    assign ps_bus.tick = tick_ff;
    assign ps_bus.clr  = clear_any;
    assign ps_bus.sel  = cfg_ps;

    wdt_postscaler u_postscaler (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .ps_bus    (ps_bus)
    );

    // Expiry action: reset when running, wake when asleep
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reset_ff <= 1'b0;
            wake_ff  <= 1'b0;
        end else begin
            reset_ff <= ps_bus.expire && !sleeping_i;
            wake_ff  <= ps_bus.expire && sleeping_i;
        end
    end

    // Timeout flag, active low; expiry beats a clear instruction
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            to_ff <= 1'b1;
        end else if (ps_bus.expire) begin
            to_ff <= 1'b0;
        end else if (clear_instr_i || sleep_instr_i) begin
            to_ff <= 1'b1;
        end
    end

    // Sticky events; a new event wins over a write-one clear
    assign ev_set[wdt_pkg::EV_TIMEOUT] = ps_bus.expire;
    assign ev_set[wdt_pkg::EV_CLEARED] = clear_instr_i || freq_chg ||
                                         fail_edge;
    assign w1c = hit(we_i, addr_i, wdt_pkg::STAT_OFS) ?
                 wdata_i[wdt_pkg::EV_WIDTH-1:0] : '0;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= (stat_ff & ~w1c) | ev_set;
        end
    end

    // Interrupt mask register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mask_ff <= '0;
        end else if (hit(we_i, addr_i, wdt_pkg::MASK_OFS)) begin
            mask_ff <= wdata_i[wdt_pkg::EV_WIDTH-1:0];
        end
    end

    // Interrupt level; one cycle behind status, kept registered
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(stat_ff & mask_ff);
        end
    end

    // Read multiplexer; unmapped offsets read as zero
    always_comb begin
        nxt_rdata = wdt_pkg::DATA_ZERO;
        unique case (addr_i)
            wdt_pkg::CTRL_OFS: nxt_rdata = ctrl_ff;
            wdt_pkg::CFG_OFS:  nxt_rdata = config_word_i & wdt_pkg::CFG_MASK;
            wdt_pkg::RSTC_OFS: nxt_rdata[wdt_pkg::TO_BIT] = to_ff;
            wdt_pkg::STAT_OFS: nxt_rdata = {6'h00, stat_ff};
            wdt_pkg::MASK_OFS: nxt_rdata = {6'h00, mask_ff};
            wdt_pkg::OSCF_OFS: nxt_rdata = {5'h00, oscf_ff};
            default:           nxt_rdata = wdt_pkg::DATA_ZERO;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_ff <= wdt_pkg::DATA_ZERO;
        end else if (re_i) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= wdt_pkg::DATA_ZERO;
        end
    end

    assign rdata_o      = rdata_ff;
    assign osc_enable_o = en_ff;
    assign dev_reset_o  = reset_ff;
    assign wake_o       = wake_ff;
    assign irq_o        = irq_ff;

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_expire_awake;
        ps_bus.expire && !sleeping_i;
    endsequence

    sequence s_reset_and_flag;
        dev_reset_o && !to_ff;
    endsequence

    chk_osc_follows_en: assert property (
        (cfg_en == wdt_pkg::EN_ALWAYS) |=> osc_enable_o)
        else $error("Oscillator not requested while enabled");

    chk_base_tick_gap: assert property (
        $rose(tick_ff) |-> $past(div_ff) == 32'(TICK_CYCLES - 1))
        else $error("Base tick at wrong count");

    chk_expire_resets: assert property (
        s_expire_awake |=> s_reset_and_flag)
        else $error("Expiry did not reset and clear flag");

    chk_expire_wakes: assert property (
        (ps_bus.expire && sleeping_i) |=> wake_o && !dev_reset_o)
        else $error("Expiry in sleep did not wake");

    chk_clear_instr: assert property (
        (clear_instr_i || sleep_instr_i) |=> div_ff == 32'h0 && !tick_ff)
        else $error("Instruction did not clear counter");

    chk_freq_clears: assert property (
        freq_chg |=> div_ff == 32'h0 ##1 div_ff <= 32'h1)
        else $error("Frequency change did not clear counter");

    chk_fail_clears: assert property (
        $rose(fail_s2_ff) |=> div_ff == 32'h0)
        else $error("Clock failure did not clear counter");

    chk_soft_ignored: assert property (
        (cfg_en == wdt_pkg::EN_OFF && ctrl_ff[wdt_pkg::SWEN_BIT])
            |=> !osc_enable_o)
        else $error("Software enable acted outside its mode");

    chk_ctrl_upper_zero: assert property (
        hit(re_i, addr_i, wdt_pkg::CTRL_OFS) |=> rdata_o[7:1] == 7'h00)
        else $error("Control upper bits not zero");

    chk_ctrl_readback: assert property (
        hit(we_i, addr_i, wdt_pkg::CTRL_OFS) ##1
            hit(re_i, addr_i, wdt_pkg::CTRL_OFS)
            |=> rdata_o[0] == $past(wdata_i[0], 2))
        else $error("Control bit did not read back");
endmodule

// ==== watchdog_timer_postscaled_test.sv ====
// Purpose: Self-checking bench for the postscaled watchdog
// Assumes: Base tick shortened to 8 cycles through TICK_CYCLES
// Notes:   Expiry latency is measured at 1:1, then scaled ratios compared
`timescale 1ns/1ps
module watchdog_timer_postscaled_test;
    localparam int TICK = 8;
    logic       ref_clk_i;
    logic       rst_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i;
    logic       we_i;
    logic       re_i;
    logic [7:0] rdata_o;
    logic [7:0] config_word_i;
    logic       clear_instr_i;
    logic       sleep_instr_i;
    logic       sleeping_i;
    logic       clk_fail_i;
    logic       osc_enable_o;
    logic       dev_reset_o;
    logic       wake_o;
    logic       irq_o;
    int         err_count = 0;
    int         cmp_count = 0;
    int         cyc_count = 0;
    int         rst_cnt   = 0;
    int         wake_cnt  = 0;
    logic [7:0] rd;
    logic [2:0] osc_sel;
    logic [4:0] mode_tab [6] = '{5'h04, 5'h1B, 5'h09, 5'h0A, 5'h10, 5'h15};
    int         n0;
    int         n;
    int         c;

    watchdog_timer_postscaled #(.TICK_CYCLES(TICK)) watchdog_timer_postscaled_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .config_word_i(config_word_i), .clear_instr_i(clear_instr_i),
        .sleep_instr_i(sleep_instr_i), .sleeping_i(sleeping_i),
        .clk_fail_i(clk_fail_i), .osc_enable_o(osc_enable_o),
        .dev_reset_o(dev_reset_o), .wake_o(wake_o), .irq_o(irq_o));

    // Free-running 100 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // Pulse counters and hang guard; a stuck run still reaches the verdict
    always @(posedge ref_clk_i) begin
        cyc_count <= cyc_count + 1;
        if (dev_reset_o === 1'b1) rst_cnt <= rst_cnt + 1;
        if (wake_o === 1'b1) wake_cnt <= wake_cnt + 1;
        if (cyc_count == 20000) begin
            err_count = err_count + 1;
            end_sim();
        end
    end

    task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_n(input int exp, input int got);
        cmp_count++;
        if (got != exp) begin
            err_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // One-cycle write strobe beside address and data
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge ref_clk_i);
        we_i <= 1'b0;
    endtask

    // Read data is taken only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge ref_clk_i);
        re_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // Clearing events: 0 clear, 1 sleep, 2 freq change, 3 clock failure
    task automatic fire(input int kind);
        case (kind)
            0: begin
                @(posedge ref_clk_i) clear_instr_i <= 1'b1;
                @(posedge ref_clk_i) clear_instr_i <= 1'b0;
            end
            1: begin
                @(posedge ref_clk_i) sleep_instr_i <= 1'b1;
                @(posedge ref_clk_i) sleep_instr_i <= 1'b0;
            end
            2: begin
                osc_sel = (osc_sel == 3'h1) ? 3'h2 : 3'h1;
                wr(wdt_pkg::OSCF_OFS, {5'h00, osc_sel});
            end
            default: begin
                @(posedge ref_clk_i) clk_fail_i <= 1'b1;
                repeat (3) @(posedge ref_clk_i);
                clk_fail_i <= 1'b0;
            end
        endcase
    endtask

    task automatic set_cfg(input logic [3:0] sel, input logic [1:0] en);
        @(posedge ref_clk_i) config_word_i <= {2'h0, sel, en};
        repeat (3) @(posedge ref_clk_i);
    endtask

    // Two clears drain any expiry already in flight, then count to expiry
    task automatic time_expiry(output int cycles);
        int base;
        fire(0);
        repeat (4) @(posedge ref_clk_i);
        fire(0);
        #1 base = rst_cnt + wake_cnt;
        cycles = 0;
        while (rst_cnt + wake_cnt == base && cycles < 2000) begin
            @(posedge ref_clk_i);
            #1 cycles++;
        end
    endtask

    task automatic end_sim;
        $display("counts: compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        rst_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        we_i = 1'b0;
        re_i = 1'b0;
        config_word_i = 8'hC4;
        clear_instr_i = 1'b0;
        sleep_instr_i = 1'b0;
        sleeping_i = 1'b0;
        clk_fail_i = 1'b0;
        osc_sel = 3'h4;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        // Reset values, read-only and unmapped places
        rd_reg(wdt_pkg::CTRL_OFS, rd); chk8(8'h00, rd);
        rd_reg(wdt_pkg::RSTC_OFS, rd); chk8(8'h08, rd & 8'h08);
        rd_reg(wdt_pkg::STAT_OFS, rd); chk8(8'h00, rd);
        wr(wdt_pkg::CFG_OFS, 8'h3B);
        rd_reg(wdt_pkg::CFG_OFS, rd); chk8(8'h04, rd);
        wr(4'hF, 8'hFF);
        rd_reg(4'hF, rd); chk8(8'h00, rd);
        @(posedge ref_clk_i) #1 chk8(8'h00, rdata_o);
        wr(wdt_pkg::CTRL_OFS, 8'hFF);
        rd_reg(wdt_pkg::CTRL_OFS, rd); chk8(8'h01, rd);
        wr(wdt_pkg::CTRL_OFS, 8'hFE);
        rd_reg(wdt_pkg::CTRL_OFS, rd); chk8(8'h00, rd);
        wr(wdt_pkg::OSCF_OFS, {5'h00, osc_sel});
        $display("test registers done");
        // Enable modes against oscillator request and expiry activity
        for (int i = 0; i < 6; i++) begin
            wr(wdt_pkg::CTRL_OFS, {7'h00, mode_tab[i][2]});
            sleeping_i <= mode_tab[i][1];
            set_cfg(4'h0, mode_tab[i][4:3]);
            chk8({7'h00, mode_tab[i][0]}, {7'h00, osc_enable_o});
            c = rst_cnt + wake_cnt;
            repeat (40) @(posedge ref_clk_i);
            chk_n(mode_tab[i][0], int'(rst_cnt + wake_cnt != c));
        end
        sleeping_i <= 1'b0;
        $display("test modes done");
        // Period scaling by the postscale select field
        set_cfg(4'h0, wdt_pkg::EN_ALWAYS);
        time_expiry(n0);
        chk_n(1, int'(n0 >= TICK && n0 <= TICK + 4));
        for (int s = 1; s < 5; s++) begin
            set_cfg(s[3:0], wdt_pkg::EN_ALWAYS);
            time_expiry(n);
            chk_n(n0 + ((1 << s) - 1) * TICK, n);
        end
        rd_reg(wdt_pkg::RSTC_OFS, rd); chk8(8'h00, rd & 8'h08);
        $display("test periods done");
        // Each clearing event repeated faster than the period stops expiry
        set_cfg(4'h1, wdt_pkg::EN_ALWAYS);
        for (int k = 0; k < 4; k++) begin
            fire(0);
            repeat (4) @(posedge ref_clk_i);
            fire(0);
            wr(wdt_pkg::STAT_OFS, 8'hFF);
            #1 c = rst_cnt + wake_cnt;
            for (int j = 0; j < 6; j++) begin
                fire(k);
                repeat (6) @(posedge ref_clk_i);
            end
            chk_n(c, rst_cnt + wake_cnt);
            // Sleep clears the count but does not raise the cleared event
            rd_reg(wdt_pkg::STAT_OFS, rd);
            chk8((k == 1) ? 8'h00 : 8'h02, rd);
        end
        rd_reg(wdt_pkg::RSTC_OFS, rd); chk8(8'h08, rd & 8'h08);
        $display("test clears done");
        // Expiry while asleep wakes instead of resetting
        set_cfg(4'h0, wdt_pkg::EN_ALWAYS);
        sleeping_i <= 1'b1;
        #1 c = rst_cnt;
        n = wake_cnt;
        time_expiry(n0);
        chk_n(c, rst_cnt);
        chk_n(n + 1, wake_cnt);
        sleeping_i <= 1'b0;
        $display("test wake done");
        // Masked and unmasked interrupt, then write-one-to-clear
        set_cfg(4'h0, wdt_pkg::EN_OFF);
        wr(wdt_pkg::MASK_OFS, 8'h00);
        rd_reg(wdt_pkg::STAT_OFS, rd); chk8(8'h03, rd);
        chk8(8'h00, {7'h00, irq_o});
        wr(wdt_pkg::MASK_OFS, 8'h01);
        repeat (2) @(posedge ref_clk_i);
        #1 chk8(8'h01, {7'h00, irq_o});
        wr(wdt_pkg::STAT_OFS, 8'h01);
        repeat (2) @(posedge ref_clk_i);
        #1 chk8(8'h00, {7'h00, irq_o});
        rd_reg(wdt_pkg::STAT_OFS, rd); chk8(8'h02, rd);
        rd_reg(wdt_pkg::MASK_OFS, rd); chk8(8'h01, rd);
        $display("test interrupt done");
        end_sim();
    end
endmodule
